/* dra_pkg.sv */
// Operation
// RL1: Core may write most debug registers but never read them; host reads some, writes all.
// RL2: With processor write inhibit set, core writes to breakpoint registers are dropped.
// RL3: Host must not send commands while the core runs its debug-register write.
// RL4: Every register is a 32-bit value; unimplemented bits reserved, written as zero.
// RL5: Host register read and write commands carry a 5-bit register select field.
// RL6: Unassigned register select codes must not be used by host or software.
// RL7: Byte commands read or write only the top byte of the three extended registers.
// RL8: A 32-bit host write to an extended register changes only bits 23 to 0.
// RL9: Host register read returns the status registers; other control registers are write-only.
// RL10: Register select codes decode to the fixed set of debug registers.
// RL11: Reset loads status and attribute values, clears trigger regs, keeps PC0, mask, high.
// RL12: Reset clears bit 0 of PC breakpoint registers one, two and three.
// RL13: Triggers form a one-level or two-level sequence from PC, address and data matches.
// RL14: A fired trigger either halts the core or raises a debug interrupt.
// RL15: Four independent PC breakpoint comparators feed the triggers.
// RL16: Operand address breakpoint matches a range between low and high bounds.
// RL17: Optional data breakpoint compares only bits not set in the data mask.
// RL18: Host and software keep their accesses serialized; the block does not arbitrate. Here the host wins and a same-cycle core write is dropped.
package dra_pkg;

    localparam logic [4:0]  SEL_DCS   = 5'h00; // RL10
    localparam logic [4:0]  SEL_XCFG  = 5'h01;
    localparam logic [4:0]  SEL_CS2   = 5'h02;
    localparam logic [4:0]  SEL_CS3   = 5'h03;
    localparam logic [4:0]  SEL_DAAT  = 5'h05;
    localparam logic [4:0]  SEL_TATM  = 5'h06;
    localparam logic [4:0]  SEL_TDF   = 5'h07;
    localparam logic [4:0]  SEL_PCB0  = 5'h08;
    localparam logic [4:0]  SEL_PCBM  = 5'h09;
    localparam logic [4:0]  SEL_ADHI  = 5'h0c;
    localparam logic [4:0]  SEL_ADLO  = 5'h0d;
    localparam logic [4:0]  SEL_DBV   = 5'h0e;
    localparam logic [4:0]  SEL_DMSK  = 5'h0f;
    localparam logic [4:0]  SEL_PCB1  = 5'h18;
    localparam logic [4:0]  SEL_PCB2  = 5'h1a;
    localparam logic [4:0]  SEL_PCB3  = 5'h1b;

    localparam logic [31:0] DCS_RST   = 32'h0090_0000; // RL11
    localparam logic [31:0] ATTR_RST  = 32'h0000_0005;
    localparam logic [31:0] XCFG_RST  = 32'h0000_0000;
    localparam logic [31:0] CS2_RST   = 32'h0000_0000;
    localparam logic [31:0] CS3_RST   = 32'h0000_0000;
    localparam logic [31:0] DCS_WMASK = 32'h0005_ffff;
    localparam logic [31:0] LOW_MASK  = 32'h00ff_ffff;
    localparam logic [3:0]  HRL_VAL   = 4'h9;

    localparam int DCS_PWI  = 16;
    localparam int DCS_BKD  = 18;
    localparam int DCS_BKPT = 24;
    localparam int DCS_HALT = 25;
    localparam int DCS_TRG  = 26;
    localparam int DCS_FOF  = 27;

    localparam int TDF_L2   = 16;
    localparam int LVL_EN   = 0;
    localparam int LVL_PC   = 1;
    localparam int LVL_ADR  = 2;
    localparam int LVL_DAT  = 3;
    localparam int LVL_IRQ  = 4;

    localparam logic [3:0]  BST_OFF   = 4'h0;
    localparam logic [3:0]  BST_WAIT1 = 4'h1;
    localparam logic [3:0]  BST_HIT1  = 4'h2;
    localparam logic [3:0]  BST_WAIT2 = 4'h5;
    localparam logic [3:0]  BST_HIT2  = 4'h6;

    typedef enum logic [2:0] {
        CMD_RD_DREG = 3'h0,
        CMD_WR_DREG = 3'h1,
        CMD_RD_XB   = 3'h2,
        CMD_RD_C2B  = 3'h3,
        CMD_RD_C3B  = 3'h4,
        CMD_WR_XB   = 3'h5,
        CMD_WR_C2B  = 3'h6,
        CMD_WR_C3B  = 3'h7
    } dra_cmd_e;

    typedef enum logic [4:0] {
        TRG_IDLE  = 5'b00001,
        TRG_WAIT1 = 5'b00010,
        TRG_HIT1  = 5'b00100,
        TRG_WAIT2 = 5'b01000,
        TRG_HIT2  = 5'b10000
    } dra_trig_e;

    typedef struct packed {
        logic        valid;
        dra_cmd_e    cmd;
        logic [4:0]  sel;
        logic [31:0] wdata;
    } dra_host_req_s;

    typedef struct packed {
        logic        valid;
        logic        supervisor;
        logic [4:0]  sel;
        logic [31:0] wdata;
    } dra_core_req_s;

    typedef struct packed {
        logic [31:0] pc;
        logic        pc_valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic        op_valid;
    } dra_exec_s;

    typedef struct packed {
        logic fault;
        logic halt_insn;
        logic bkpt;
        logic go;
    } dra_event_s;

    typedef struct packed {
        logic [31:0] xcfg;
        logic [31:0] cs2;
        logic [31:0] cs3;
        logic [31:0] daat;
        logic [31:0] tatm;
    } dra_cfg_s;

endpackage

/* dra_pc_match.sv */
`timescale 1ns/1ps
module dra_pc_match (
    input  wire logic        [31:0] pc_i,
    input  wire logic               pc_valid_i,
    input  wire logic        [31:0] pcb0_i,
    input  wire logic        [31:0] pcbm_i,
    input  wire logic [2:0]  [30:0] pbr_hi_i,
    input  wire logic        [2:0]  pbr_en_i,
    output logic                    hit_o
);

    logic [3:0] hits;

    // Set mask bits exclude that PC bit from comparator zero
    always_comb begin
        hits[0] = (((pc_i ^ pcb0_i) & ~pcbm_i) == 32'h0000_0000); // RL15
        for (int i = 0; i < 3; i++) begin
            hits[i + 1] = pbr_en_i[i] & (pc_i[31:1] == pbr_hi_i[i]); // RL15
        end
        hit_o = pc_valid_i & (|hits);
    end

endmodule

/* dra_debug_regs.sv */
`timescale 1ns/1ps
module dra_debug_regs (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_n_i,
    input  wire dra_pkg::dra_host_req_s host_req_i,
    output logic               [31:0]  host_rdata_o,
    output logic                       host_rvalid_o,
    input  wire dra_pkg::dra_core_req_s core_req_i,
    output logic                       core_blocked_o,
    input  wire dra_pkg::dra_exec_s     exec_i,
    input  wire dra_pkg::dra_event_s    event_i,
    output logic                       halt_req_o,
    output logic                       debug_irq_o,
    output dra_pkg::dra_cfg_s           cfg_o
);

    typedef struct packed {
        logic [31:0]         dcs;
        logic [31:0]         xcfg;
        logic [31:0]         cs2;
        logic [31:0]         cs3;
        logic [31:0]         daat;
        logic [31:0]         tatm;
        logic [31:0]         tdf;
        logic [31:0]         adlo;
        logic [31:0]         dbv;
        logic [31:0]         dmsk;
        logic [2:0]          pbr_en;
        dra_pkg::dra_trig_e  trig;
        logic [31:0]         rdata;
        logic                rvalid;
        logic                halt;
        logic                irq;
        logic                blocked;
    } dra_state_s;

    // Registers that reset leaves untouched
    typedef struct packed {
        logic [31:0]         pcb0;
        logic [31:0]         pcbm;
        logic [31:0]         adhi;
        logic [2:0] [30:0]   pbr_hi;
    } dra_keep_s;

    dra_state_s st_reg;
    dra_state_s st_next;
    dra_keep_s  kp_reg;
    dra_keep_s  kp_next;
    logic       pc_hit;

    function automatic logic is_bkpt_reg(input logic [4:0] sel);
        case (sel)
            dra_pkg::SEL_DAAT, dra_pkg::SEL_TATM, dra_pkg::SEL_TDF,
            dra_pkg::SEL_PCB0, dra_pkg::SEL_PCBM, dra_pkg::SEL_ADHI,
            dra_pkg::SEL_ADLO, dra_pkg::SEL_DBV,  dra_pkg::SEL_DMSK,
            dra_pkg::SEL_PCB1, dra_pkg::SEL_PCB2, dra_pkg::SEL_PCB3: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    // Keeps the top byte, takes bits 23..0 from the writer
    function automatic logic [31:0] low24(input logic [31:0] old, input logic [31:0] wd);
        return (old & ~dra_pkg::LOW_MASK) | (wd & dra_pkg::LOW_MASK);
    endfunction

    function automatic logic [31:0] top8(input logic [31:0] old, input logic [31:0] wd);
        return {wd[7:0], old[23:0]};
    endfunction

    function automatic logic [3:0] bstat(input dra_pkg::dra_trig_e t);
        case (t)
            dra_pkg::TRG_WAIT1: begin
                return dra_pkg::BST_WAIT1;
            end
            dra_pkg::TRG_HIT1: begin
                return dra_pkg::BST_HIT1;
            end
            dra_pkg::TRG_WAIT2: begin
                return dra_pkg::BST_WAIT2;
            end
            dra_pkg::TRG_HIT2: begin
                return dra_pkg::BST_HIT2;
            end
            default: begin
                return dra_pkg::BST_OFF;
            end
        endcase
    endfunction

    // One level of the trigger: PC, address range and data terms
    function automatic logic lvl_hit(input logic [15:0] cfg, input logic pc_h,
                                     input logic rng_h, input logic dat_h);
        logic op_h;
        op_h = (cfg[dra_pkg::LVL_ADR] | cfg[dra_pkg::LVL_DAT])
             & (~cfg[dra_pkg::LVL_ADR] | rng_h)
             & (~cfg[dra_pkg::LVL_DAT] | dat_h);
        return (cfg[dra_pkg::LVL_PC] & pc_h) | op_h; // RL13
    endfunction

    dra_pc_match u_pc_match (
        .pc_i       (exec_i.pc),
        .pc_valid_i (exec_i.pc_valid),
        .pcb0_i     (kp_reg.pcb0),
        .pcbm_i     (kp_reg.pcbm),
        .pbr_hi_i   (kp_reg.pbr_hi),
        .pbr_en_i   (st_reg.pbr_en),
        .hit_o      (pc_hit)
    );

    always_comb begin
        logic        host_v;
        logic        host_wr;
        logic        core_v;
        logic        wen;
        logic [4:0]  wsel;
        logic [31:0] wd;
        logic        rng_h;
        logic        dat_h;
        logic        h1;
        logic        h2;
        logic        csr_rd;
        logic        trig_clr;
        logic        fire;
        logic        fire_irq;
        host_v   = host_req_i.valid;
        host_wr  = 1'b0;
        core_v   = 1'b0;
        wen      = 1'b0;
        wsel     = host_req_i.sel;
        wd       = host_req_i.wdata;
        rng_h    = 1'b0;
        dat_h    = 1'b0;
        h1       = 1'b0;
        h2       = 1'b0;
        csr_rd   = 1'b0;
        trig_clr = 1'b0;
        fire     = 1'b0;
        fire_irq = 1'b0;
        st_next  = st_reg;
        kp_next  = kp_reg;
        st_next.rvalid  = 1'b0;
        st_next.halt    = 1'b0;
        st_next.irq     = 1'b0;
        st_next.blocked = 1'b0;

        // Host has the port when both ask in one cycle; no further arbitration
        host_wr = host_v & (host_req_i.cmd == dra_pkg::CMD_WR_DREG); // RL5 RL18
        if (!host_v && core_req_i.valid && core_req_i.supervisor) begin
            if (st_reg.dcs[dra_pkg::DCS_PWI] && is_bkpt_reg(core_req_i.sel)) begin
                st_next.blocked = 1'b1; // RL2
            end else begin
                core_v = 1'b1; // RL1
            end
        end
        wen = host_wr | core_v;
        if (core_v) begin
            wsel = core_req_i.sel;
            wd   = core_req_i.wdata;
        end

        // Full-word writes by select code
        if (wen) begin
            case (wsel) // RL10
                dra_pkg::SEL_DCS: begin
                    st_next.dcs = (st_reg.dcs & ~dra_pkg::DCS_WMASK)
                                | (wd & dra_pkg::DCS_WMASK); // RL4
                end
                dra_pkg::SEL_XCFG: begin
                    st_next.xcfg = low24(st_reg.xcfg, wd); // RL8
                end
                dra_pkg::SEL_CS2: begin
                    st_next.cs2 = low24(st_reg.cs2, wd); // RL8
                end
                dra_pkg::SEL_CS3: begin
                    st_next.cs3 = low24(st_reg.cs3, wd); // RL8
                end
                dra_pkg::SEL_DAAT: begin
                    st_next.daat = wd;
                end
                dra_pkg::SEL_TATM: begin
                    st_next.tatm = wd;
                end
                dra_pkg::SEL_TDF: begin
                    st_next.tdf = wd;
                    trig_clr    = 1'b1;
                end
                dra_pkg::SEL_PCB0: begin
                    kp_next.pcb0 = wd;
                end
                dra_pkg::SEL_PCBM: begin
                    kp_next.pcbm = wd;
                end
                dra_pkg::SEL_ADHI: begin
                    kp_next.adhi = wd; // RL16
                end
                dra_pkg::SEL_ADLO: begin
                    st_next.adlo = wd; // RL16
                end
                dra_pkg::SEL_DBV: begin
                    st_next.dbv = wd; // RL17
                end
                dra_pkg::SEL_DMSK: begin
                    st_next.dmsk = wd; // RL17
                end
                dra_pkg::SEL_PCB1: begin
                    kp_next.pbr_hi[0] = wd[31:1];
                    st_next.pbr_en[0] = wd[0];
                end
                dra_pkg::SEL_PCB2: begin
                    kp_next.pbr_hi[1] = wd[31:1];
                    st_next.pbr_en[1] = wd[0];
                end
                dra_pkg::SEL_PCB3: begin
                    kp_next.pbr_hi[2] = wd[31:1];
                    st_next.pbr_en[2] = wd[0];
                end
                default: begin
                end
            endcase
        end

        // Host reads and top-byte accesses
        if (host_v) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = 32'h0000_0000;
            case (host_req_i.cmd)
                dra_pkg::CMD_RD_DREG: begin
                    case (host_req_i.sel) // RL9
                        dra_pkg::SEL_DCS: begin
                            st_next.rdata = {bstat(st_reg.trig), st_reg.dcs[27:24],
                                             dra_pkg::HRL_VAL, st_reg.dcs[19:0]};
                            csr_rd = 1'b1;
                        end
                        dra_pkg::SEL_XCFG: begin
                            st_next.rdata = st_reg.xcfg;
                        end
                        dra_pkg::SEL_CS2: begin
                            st_next.rdata = st_reg.cs2;
                        end
                        dra_pkg::SEL_CS3: begin
                            st_next.rdata = st_reg.cs3;
                        end
                        default: begin
                        end
                    endcase
                end
                dra_pkg::CMD_RD_XB: begin
                    st_next.rdata = {24'h00_0000, st_reg.xcfg[31:24]}; // RL7
                end
                dra_pkg::CMD_RD_C2B: begin
                    st_next.rdata = {24'h00_0000, st_reg.cs2[31:24]}; // RL7
                end
                dra_pkg::CMD_RD_C3B: begin
                    st_next.rdata = {24'h00_0000, st_reg.cs3[31:24]}; // RL7
                end
                dra_pkg::CMD_WR_XB: begin
                    st_next.xcfg = top8(st_reg.xcfg, host_req_i.wdata); // RL7
                end
                dra_pkg::CMD_WR_C2B: begin
                    st_next.cs2 = top8(st_reg.cs2, host_req_i.wdata); // RL7
                end
                dra_pkg::CMD_WR_C3B: begin
                    st_next.cs3 = top8(st_reg.cs3, host_req_i.wdata); // RL7
                end
                default: begin
                end
            endcase
        end

        // Match terms for the operand side
        rng_h = exec_i.op_valid & (exec_i.addr >= st_reg.adlo)
              & (exec_i.addr <= kp_reg.adhi); // RL16
        dat_h = exec_i.op_valid
              & (((exec_i.data ^ st_reg.dbv) & ~st_reg.dmsk) == 32'h0000_0000); // RL17
        h1 = lvl_hit(st_reg.tdf[15:0], pc_hit, rng_h, dat_h);
        h2 = lvl_hit(st_reg.tdf[31:16], pc_hit, rng_h, dat_h);

        // Trigger sequence
        case (st_reg.trig)
            dra_pkg::TRG_IDLE: begin
                if (st_reg.tdf[dra_pkg::LVL_EN]) begin
                    st_next.trig = dra_pkg::TRG_WAIT1;
                end
            end
            dra_pkg::TRG_WAIT1: begin
                if (h1) begin
                    if (st_reg.tdf[dra_pkg::TDF_L2 + dra_pkg::LVL_EN]) begin
                        st_next.trig = dra_pkg::TRG_WAIT2; // RL13
                    end else begin
                        st_next.trig = dra_pkg::TRG_HIT1;
                        fire         = 1'b1;
                        fire_irq     = st_reg.tdf[dra_pkg::LVL_IRQ];
                    end
                end
            end
            dra_pkg::TRG_WAIT2: begin
                if (h2) begin
                    st_next.trig = dra_pkg::TRG_HIT2; // RL13
                    fire         = 1'b1;
                    fire_irq     = st_reg.tdf[dra_pkg::TDF_L2 + dra_pkg::LVL_IRQ];
                end
            end
            dra_pkg::TRG_HIT1, dra_pkg::TRG_HIT2: begin
                if (csr_rd) begin
                    st_next.trig = dra_pkg::TRG_IDLE;
                end
            end
            default: begin
                st_next.trig = dra_pkg::TRG_IDLE;
            end
        endcase
        if (trig_clr) begin
            st_next.trig = dra_pkg::TRG_IDLE;
            fire         = 1'b0;
        end

        // Halt or interrupt response
        st_next.halt = fire & ~fire_irq; // RL14
        st_next.irq  = fire & fire_irq; // RL14
        if (event_i.bkpt && st_reg.dcs[dra_pkg::DCS_BKD]) begin
            st_next.irq = 1'b1;
        end

        // Status flags: clears first, so a same-cycle event still sets
        if (csr_rd) begin
            st_next.dcs[dra_pkg::DCS_FOF]  = 1'b0;
            st_next.dcs[dra_pkg::DCS_TRG]  = 1'b0;
            st_next.dcs[dra_pkg::DCS_HALT] = 1'b0;
            st_next.dcs[dra_pkg::DCS_BKPT] = 1'b0;
        end
        if (event_i.go) begin
            st_next.dcs[dra_pkg::DCS_TRG]  = 1'b0;
            st_next.dcs[dra_pkg::DCS_HALT] = 1'b0;
            st_next.dcs[dra_pkg::DCS_BKPT] = 1'b0;
        end
        if (event_i.fault) begin
            st_next.dcs[dra_pkg::DCS_FOF] = 1'b1;
        end
        if (event_i.halt_insn) begin
            st_next.dcs[dra_pkg::DCS_HALT] = 1'b1;
        end
        if (event_i.bkpt && !st_reg.dcs[dra_pkg::DCS_BKD]) begin
            st_next.dcs[dra_pkg::DCS_BKPT] = 1'b1;
        end
        if (st_next.halt) begin
            st_next.dcs[dra_pkg::DCS_TRG] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg         <= '0;
            st_reg.dcs     <= dra_pkg::DCS_RST; // RL11
            st_reg.xcfg    <= dra_pkg::XCFG_RST;
            st_reg.cs2     <= dra_pkg::CS2_RST;
            st_reg.cs3     <= dra_pkg::CS3_RST;
            st_reg.daat    <= dra_pkg::ATTR_RST; // RL11
            st_reg.tatm    <= dra_pkg::ATTR_RST; // RL11
            st_reg.pbr_en  <= 3'h0; // RL12
            st_reg.trig    <= dra_pkg::TRG_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // No reset: these keep their contents across reset
    always_ff @(posedge mclk_i) begin
        kp_reg <= kp_next; // RL11
    end

    assign host_rdata_o   = st_reg.rdata;
    assign host_rvalid_o  = st_reg.rvalid;
    assign core_blocked_o = st_reg.blocked;
    assign halt_req_o     = st_reg.halt;
    assign debug_irq_o    = st_reg.irq;
    assign cfg_o          = '{st_reg.xcfg, st_reg.cs2, st_reg.cs3, st_reg.daat, st_reg.tatm};

endmodule

/* dra_debug_regs_checker.sv */
`timescale 1ns/1ps
module dra_debug_regs_checker (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire dra_pkg::dra_host_req_s host_req_i,
    input  wire logic [31:0]            host_rdata_o,
    input  wire logic                   host_rvalid_o,
    input  wire dra_pkg::dra_core_req_s core_req_i,
    input  wire logic                   core_blocked_o,
    input  wire dra_pkg::dra_exec_s     exec_i,
    input  wire dra_pkg::dra_event_s    event_i,
    input  wire logic                   halt_req_o,
    input  wire logic                   debug_irq_o,
    input  wire dra_pkg::dra_cfg_s      cfg_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_rvalid_next: assert property (host_req_i.valid |=> host_rvalid_o)
        else $error("no answer to host command");
    chk_rvalid_cause: assert property (host_rvalid_o |-> $past(host_req_i.valid))
        else $error("answer without host command");
    chk_write_zero: assert property (host_req_i.valid && host_req_i.cmd inside
        {dra_pkg::CMD_WR_DREG, dra_pkg::CMD_WR_XB, dra_pkg::CMD_WR_C2B, dra_pkg::CMD_WR_C3B}
        |=> host_rdata_o == 32'h0)
        else $error("write command returned data");
    chk_wo_read_zero: assert property (host_req_i.valid && host_req_i.sel >= 5'h05
        && host_req_i.cmd == dra_pkg::CMD_RD_DREG |=> host_rdata_o == 32'h0)
        else $error("write-only register readable");
    chk_byte_read: assert property (host_req_i.valid && host_req_i.cmd == dra_pkg::CMD_RD_XB
        |=> host_rdata_o == {24'h0, $past(cfg_o.xcfg[31:24])})
        else $error("byte read wrong");
    chk_byte_write: assert property (host_req_i.valid && host_req_i.cmd == dra_pkg::CMD_WR_XB
        |=> ##1 cfg_o.xcfg[31:24] == $past(host_req_i.wdata[7:0], 2))
        else $error("byte write lost");
    chk_top_kept: assert property (host_req_i.valid && host_req_i.sel == 5'h01
        && host_req_i.cmd == dra_pkg::CMD_WR_DREG
        |=> ##1 cfg_o.xcfg[31:24] == $past(cfg_o.xcfg[31:24], 2))
        else $error("top byte changed by word write");
    chk_block_cause: assert property (core_blocked_o |-> $past(core_req_i.valid
        && core_req_i.supervisor && core_req_i.sel >= 5'h05))
        else $error("core write blocked without cause");
endmodule

bind dra_debug_regs dra_debug_regs_checker chk_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .host_req_i(host_req_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .core_req_i(core_req_i), .core_blocked_o(core_blocked_o), .exec_i(exec_i),
    .event_i(event_i), .halt_req_o(halt_req_o), .debug_irq_o(debug_irq_o), .cfg_o(cfg_o));

/* dra_far_model.sv */
`timescale 1ns/1ps
// Host tool and core write path; one access at a time, never both together
module dra_far_model (
    input  wire logic              mclk_i,
    input  wire logic [31:0]       host_rdata_i,
    input  wire logic              host_rvalid_i,
    input  wire logic              core_blocked_i,
    output dra_pkg::dra_host_req_s host_req_o,
    output dra_pkg::dra_core_req_s core_req_o
);
    initial begin
        host_req_o = '0;
        core_req_o = '0;
    end

    task automatic host(input dra_pkg::dra_cmd_e cmd, input logic [4:0] sel,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk_i);
        host_req_o <= '{1'b1, cmd, sel, wd};
        @(posedge mclk_i);
        host_req_o <= '{1'b0, cmd, ~sel, ~wd};
        #1;
        rd = host_rvalid_i ? host_rdata_i : 32'hxxxx_xxxx;
    endtask

    task automatic core(input logic sup, input logic [4:0] sel,
                        input logic [31:0] wd, output logic blk);
        @(posedge mclk_i);
        core_req_o <= '{1'b1, sup, sel, wd};
        @(posedge mclk_i);
        core_req_o <= '{1'b0, 1'b0, ~sel, ~wd};
        #1;
        blk = core_blocked_i;
    endtask
endmodule

/* dra_testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic                   mclk_i;
    logic                   rst_n_i;
    dra_pkg::dra_host_req_s host_req;
    dra_pkg::dra_core_req_s core_req;
    dra_pkg::dra_exec_s     exec_i;
    dra_pkg::dra_event_s    event_i;
    dra_pkg::dra_cfg_s      cfg;
    logic [31:0]            rdata;
    logic                   rvalid;
    logic                   blocked;
    logic                   halt_req;
    logic                   debug_irq;
    logic [31:0]            r;
    logic                   b;
    int                     error_cnt;
    int                     checks_done;

    dra_debug_regs uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_req_i(host_req),
        .host_rdata_o(rdata), .host_rvalid_o(rvalid), .core_req_i(core_req),
        .core_blocked_o(blocked), .exec_i(exec_i), .event_i(event_i),
        .halt_req_o(halt_req), .debug_irq_o(debug_irq), .cfg_o(cfg));
    dra_far_model far (.mclk_i(mclk_i), .host_rdata_i(rdata), .host_rvalid_i(rvalid),
        .core_blocked_i(blocked), .host_req_o(host_req), .core_req_o(core_req));

    initial mclk_i = 1'b0;
    always #5 mclk_i = ~mclk_i;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One-cycle execution event, then watch both responses for six cycles
    task automatic trig(input logic [31:0] pc, input logic [31:0] ad, input logic [1:0] exp);
        logic [1:0] seen;
        seen = 2'b00;
        @(posedge mclk_i);
        exec_i <= '{pc, pc != 0, ad, 32'h0, ad != 0};
        repeat (6) begin
            @(posedge mclk_i);
            exec_i <= '0;
            #1;
            seen = seen | {halt_req, debug_irq};
        end
        chk({30'h0, seen}, {30'h0, exp});
    endtask

    task automatic t_reset;
        far.host(dra_pkg::CMD_RD_DREG, 5'h00, '0, r);
        chk(r, 32'h0090_0000);
        far.host(dra_pkg::CMD_RD_DREG, 5'h01, '0, r);
        chk(r, 32'h0);
        chk(cfg.daat, 32'h0000_0005);
        chk(cfg.tatm, 32'h0000_0005);
        far.host(dra_pkg::CMD_WR_DREG, 5'h07, 32'h0000_0010, r);
        far.host(dra_pkg::CMD_RD_DREG, 5'h07, '0, r);
        chk(r, 32'h0);
        far.host(dra_pkg::CMD_RD_DREG, 5'h0d, '0, r);
        chk(r, 32'h0);
    endtask

    task automatic t_ext;
        logic [4:0] s;
        logic [7:0] v;
        for (int i = 0; i < 3; i++) begin
            s = 5'h01 + 5'(i);
            v = 8'h5a + 8'(i);
            far.host(dra_pkg::dra_cmd_e'(3'h5 + 3'(i)), s, {24'h0, v}, r);
            far.host(dra_pkg::CMD_WR_DREG, s, 32'hff12_3450, r);
            far.host(dra_pkg::dra_cmd_e'(3'h2 + 3'(i)), s, '0, r);
            chk(r, {24'h0, v});
            far.host(dra_pkg::CMD_RD_DREG, s, '0, r);
            chk(r, {v, 24'h12_3450});
        end
    endtask

    task automatic t_inhibit;
        far.host(dra_pkg::CMD_WR_DREG, 5'h00, 32'h0001_0000, r);
        far.core(1'b1, 5'h0e, 32'h0000_00ff, b);
        chk({31'h0, b}, 32'h1);
        far.core(1'b1, 5'h01, 32'h0000_00a0, b);
        chk({31'h0, b}, 32'h0);
        far.host(dra_pkg::CMD_WR_DREG, 5'h00, 32'h0, r);
        far.core(1'b1, 5'h05, 32'h0000_0003, b);
        far.core(1'b0, 5'h06, 32'h0000_0003, b);
        repeat (2) @(posedge mclk_i);
        chk(cfg.xcfg, 32'h5a00_00a0);
        chk(cfg.daat, 32'h0000_0003);
        chk(cfg.tatm, 32'h0000_0005);
    endtask

    task automatic t_trigger;
        far.core(1'b1, 5'h08, 32'hffff_fff0, b);
        far.core(1'b1, 5'h09, 32'h0, b);
        far.core(1'b1, 5'h18, 32'h0000_1001, b);
        far.host(dra_pkg::CMD_WR_DREG, 5'h0d, 32'h0000_2000, r);
        far.host(dra_pkg::CMD_WR_DREG, 5'h0c, 32'h0000_2fff, r);
        far.host(dra_pkg::CMD_WR_DREG, 5'h07, 32'h0000_0003, r);
        trig(32'h0000_1000, 32'h0, 2'b10);
        far.host(dra_pkg::CMD_RD_DREG, 5'h00, '0, r);
        chk(r, 32'h2490_0000);
        far.host(dra_pkg::CMD_RD_DREG, 5'h00, '0, r);
        chk(r, 32'h1090_0000);
        far.host(dra_pkg::CMD_WR_DREG, 5'h07, 32'h001d_0003, r);
        trig(32'h0000_1000, 32'h0, 2'b00);
        far.host(dra_pkg::CMD_RD_DREG, 5'h00, '0, r);
        chk(r, 32'h5090_0000);
        trig(32'h0, 32'h0000_2800, 2'b01);
        far.host(dra_pkg::CMD_RD_DREG, 5'h00, '0, r);
        chk(r, 32'h6090_0000);
    endtask

    task automatic t_event;
        @(posedge mclk_i);
        event_i <= '{1'b1, 1'b1, 1'b1, 1'b0};
        @(posedge mclk_i);
        event_i <= '0;
        far.host(dra_pkg::CMD_RD_DREG, 5'h00, '0, r);
        chk(r, 32'h1b90_0000);
    endtask

    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst_n_i = 1'b0;
        exec_i = '0;
        event_i = '0;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_ext;
        t_inhibit;
        t_trigger;
        t_event;
        wrap_up;
    end

    initial begin
        #100000;
        error_cnt++;
        wrap_up;
    end
endmodule
